// File: design/stg_pkg.sv
package stg_pkg;
	// Control mode codes.
	localparam logic [3:0] MODE_POSITION = 4'h0;
	localparam logic [3:0] MODE_VELOCITY = 4'h1;
	localparam logic [3:0] MODE_TORQUE = 4'h2;
	localparam logic [3:0] MODE_FULL_CLOSED = 4'h6;
	localparam logic [3:0] SWITCH_ON_COMMAND = 4'h7;
	localparam int unsigned SCALE_DIVISOR = 100;
	localparam logic [15:0] SCALE_UNITY = 16'h0064;
	// Register byte offsets.
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_HOLD = 8'h08;
	localparam logic [7:0] OFS_SCALE = 8'h0C;
	localparam logic [7:0] OFS_OFFSET = 8'h10;
	localparam logic [7:0] OFS_FWD = 8'h14;
	localparam logic [7:0] OFS_REV = 8'h18;
	localparam logic [7:0] OFS_TRANS = 8'h1C;
	localparam logic [7:0] OFS_GAIN1 = 8'h20;
	localparam logic [7:0] OFS_GAIN2 = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_GAINOUT = 8'h2C;
	localparam logic [7:0] OFS_COMP = 8'h30;
	// Control register bit positions.
	localparam int unsigned BIT_SERVO_ON = 0;
	localparam int unsigned BIT_SECOND_COND = 1;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		STG_GAIN_FIRST = 2'b00,
		STG_GAIN_SECOND = 2'b01,
		STG_GAIN_RAMP = 2'b10,
		STG_GAIN_THIRD = 2'b11
	} stg_gain_state_t;
	typedef enum logic [1:0] {
		STG_DIR_NONE = 2'b00,
		STG_DIR_FWD = 2'b01,
		STG_DIR_REV = 2'b10
	} stg_dir_t;
endpackage : stg_pkg

// File: design/stg_third_gain_friction.sv
`timescale 1ns/1ps
module stg_third_gain_friction #(
	parameter int unsigned GAIN_W = 16,
	parameter int unsigned TORQ_W = 16
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address, data and response.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Positional command from the host, one pulse per command.
	input wire logic cmd_valid,
	input wire logic cmd_reverse,
	// Loop inputs.
	input wire logic signed [TORQ_W-1:0] torque_in,
	// Loop outputs.
	output logic [GAIN_W-1:0] pos_loop_gain,
	output logic [GAIN_W-1:0] speed_prop_gain,
	output logic signed [TORQ_W-1:0] torque_out,
	output logic third_gain_active
);
	// Widths above the 16-bit settings would only pad the gain and torque outputs with extension bits.
	if (GAIN_W < 8 || GAIN_W > 16 || TORQ_W < 8 || TORQ_W > 16) begin : g_bad_width
		$error("stg_third_gain_friction: GAIN_W and TORQ_W must lie in 8..16");
	end

	// Software settings.
	logic servo_on;
	logic second_cond_sw;
	logic [3:0] control_mode_select;
	logic [3:0] gain_switch_condition_select;
	logic [15:0] third_gain_hold_time;
	logic [15:0] third_gain_scale;
	logic signed [15:0] offset_torque_add;
	logic signed [15:0] fwd_friction_comp;
	logic signed [15:0] rev_friction_comp;
	logic [15:0] gain_transition_time;
	logic [15:0] first_position_loop_gain;
	logic [15:0] first_speed_prop_gain;
	logic [15:0] second_position_loop_gain;
	logic [15:0] second_speed_prop_gain;

	// Loop state.
	stg_pkg::stg_gain_state_t gain_state;
	stg_pkg::stg_dir_t cmd_dir;
	logic [15:0] phase_count;
	logic cmd_seen;
	logic signed [15:0] offset_term;
	logic signed [15:0] dynamic_term;

	// Bus handshake state.
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Derived terms.
	logic pos_mode;
	logic switch_cond;
	logic [31:0] third_pos_prod;
	logic [31:0] third_spd_prod;
	logic [15:0] third_pos;
	logic [15:0] third_spd;
	logic [15:0] ramp_pos;
	logic [15:0] ramp_spd;

	assign pos_mode = (control_mode_select == stg_pkg::MODE_POSITION) ||
		(control_mode_select == stg_pkg::MODE_FULL_CLOSED);
	// Selector 7 ties the condition to a command being present; otherwise software drives it.
	assign switch_cond = (gain_switch_condition_select == stg_pkg::SWITCH_ON_COMMAND) ?
		cmd_valid : second_cond_sw;
	assign third_pos_prod = (first_position_loop_gain * third_gain_scale) /
		stg_pkg::SCALE_DIVISOR;
	assign third_spd_prod = (first_speed_prop_gain * third_gain_scale) /
		stg_pkg::SCALE_DIVISOR;
	// Saturate so a large scale factor cannot wrap the gain.
	assign third_pos = (third_pos_prod[31:16] != 16'h0000) ? 16'hFFFF : third_pos_prod[15:0];
	assign third_spd = (third_spd_prod[31:16] != 16'h0000) ? 16'hFFFF : third_spd_prod[15:0];

	// Linear blend from second to third gain; a zero time skips straight to third.
	function automatic logic [15:0] stg_blend(input logic [15:0] from_g, input logic [15:0] to_g,
		input logic [15:0] step, input logic [15:0] span);
		logic signed [33:0] diff;
		logic signed [33:0] part;
		diff = 34'(signed'({1'b0, to_g})) - 34'(signed'({1'b0, from_g}));
		// Step and span are made signed so that a falling ramp is not divided as unsigned.
		part = (span == 16'h0000) ? diff : (diff * signed'(34'(step))) / signed'(34'(span));
		stg_blend = 16'(34'(from_g) + part);
	endfunction : stg_blend

	assign ramp_pos = stg_blend(second_position_loop_gain, third_pos, phase_count,
		gain_transition_time);
	assign ramp_spd = stg_blend(second_speed_prop_gain, third_spd, phase_count,
		gain_transition_time);

	// Gain selection state; the hold counter also paces the ramp.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gain_state <= stg_pkg::STG_GAIN_FIRST;
			phase_count <= 16'h0000;
		end else if (!servo_on || !pos_mode) begin
			gain_state <= switch_cond ? stg_pkg::STG_GAIN_SECOND : stg_pkg::STG_GAIN_FIRST;
			phase_count <= 16'h0000;
		end else begin
			case (gain_state)
				stg_pkg::STG_GAIN_FIRST: begin
					if (switch_cond) begin
						gain_state <= stg_pkg::STG_GAIN_SECOND;
					end
					phase_count <= 16'h0000;
				end
				stg_pkg::STG_GAIN_SECOND: begin
					phase_count <= 16'h0000;
					if (!switch_cond) begin
						// Leaving second gain goes through the third gain, ramped in.
						gain_state <= stg_pkg::STG_GAIN_RAMP;
					end
				end
				stg_pkg::STG_GAIN_RAMP: begin
					if (switch_cond) begin
						gain_state <= stg_pkg::STG_GAIN_SECOND;
						phase_count <= 16'h0000;
					end else if (phase_count >= gain_transition_time) begin
						gain_state <= stg_pkg::STG_GAIN_THIRD;
						phase_count <= 16'h0000;
					end else begin
						phase_count <= phase_count + 16'h0001;
					end
				end
				stg_pkg::STG_GAIN_THIRD: begin
					if (switch_cond) begin
						gain_state <= stg_pkg::STG_GAIN_SECOND;
						phase_count <= 16'h0000;
					end else if (phase_count >= third_gain_hold_time) begin
						gain_state <= stg_pkg::STG_GAIN_FIRST;
						phase_count <= 16'h0000;
					end else begin
						phase_count <= phase_count + 16'h0001;
					end
				end
				default: begin
					gain_state <= stg_pkg::STG_GAIN_FIRST;
					phase_count <= 16'h0000;
				end
			endcase
		end
	end

	// Only the two proportional gains change; other loop gains stay on the first set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_loop_gain <= '0;
			speed_prop_gain <= '0;
			third_gain_active <= 1'b0;
		end else begin
			case (gain_state)
				stg_pkg::STG_GAIN_SECOND: begin
					pos_loop_gain <= GAIN_W'(second_position_loop_gain);
					speed_prop_gain <= GAIN_W'(second_speed_prop_gain);
				end
				stg_pkg::STG_GAIN_RAMP: begin
					pos_loop_gain <= GAIN_W'(ramp_pos);
					speed_prop_gain <= GAIN_W'(ramp_spd);
				end
				stg_pkg::STG_GAIN_THIRD: begin
					pos_loop_gain <= GAIN_W'(third_pos);
					speed_prop_gain <= GAIN_W'(third_spd);
				end
				default: begin
					pos_loop_gain <= GAIN_W'(first_position_loop_gain);
					speed_prop_gain <= GAIN_W'(first_speed_prop_gain);
				end
			endcase
			third_gain_active <= (gain_state == stg_pkg::STG_GAIN_THIRD) ||
				(gain_state == stg_pkg::STG_GAIN_RAMP);
		end
	end

	// Latched command direction; forgotten whenever the motor is de-energized.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_dir <= stg_pkg::STG_DIR_NONE;
			cmd_seen <= 1'b0;
		end else if (!servo_on) begin
			cmd_dir <= stg_pkg::STG_DIR_NONE;
			cmd_seen <= 1'b0;
		end else if (cmd_valid) begin
			cmd_dir <= cmd_reverse ? stg_pkg::STG_DIR_REV : stg_pkg::STG_DIR_FWD;
			cmd_seen <= 1'b1;
		end
	end

	// Compensation terms by control mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_term <= 16'sh0000;
			dynamic_term <= 16'sh0000;
		end else if (control_mode_select == stg_pkg::MODE_TORQUE) begin
			offset_term <= 16'sh0000;
			dynamic_term <= 16'sh0000;
		end else if (!pos_mode) begin
			// Velocity and mixed modes carry only the constant offset.
			offset_term <= offset_torque_add;
			dynamic_term <= 16'sh0000;
		end else if (servo_on && cmd_seen) begin
			offset_term <= offset_torque_add;
			case (cmd_dir)
				stg_pkg::STG_DIR_FWD: dynamic_term <= fwd_friction_comp;
				stg_pkg::STG_DIR_REV: dynamic_term <= rev_friction_comp;
				default: dynamic_term <= dynamic_term;
			endcase
		end
	end

	// Torque output; compensation is withheld while the servo is off.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			torque_out <= '0;
		end else if (servo_on) begin
			torque_out <= TORQ_W'(torque_in + offset_term + dynamic_term);
		end else begin
			torque_out <= torque_in;
		end
	end

	// Write channel: address and data accepted in either order, response after both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= stg_pkg::RESP_OKAY;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			// Each ready is registered: it drops when its channel is taken and returns after B.
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr <= stg_pkg::OFS_GAIN2 && aw_addr[1:0] == 2'b00) ?
					stg_pkg::RESP_OKAY : stg_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register writes; strobe bit 0 alone gates each write, and the gain registers also store the high halfword.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			servo_on <= 1'b0;
			second_cond_sw <= 1'b0;
			control_mode_select <= stg_pkg::MODE_POSITION;
			gain_switch_condition_select <= 4'h0;
			third_gain_hold_time <= 16'h0000;
			third_gain_scale <= stg_pkg::SCALE_UNITY;
			offset_torque_add <= 16'sh0000;
			fwd_friction_comp <= 16'sh0000;
			rev_friction_comp <= 16'sh0000;
			gain_transition_time <= 16'h0000;
			first_position_loop_gain <= 16'h0000;
			first_speed_prop_gain <= 16'h0000;
			second_position_loop_gain <= 16'h0000;
			second_speed_prop_gain <= 16'h0000;
		end else if (aw_held && w_held && !s_axi_bvalid && w_strb[0]) begin
			case (aw_addr)
				stg_pkg::OFS_CONTROL: begin
					servo_on <= w_data[stg_pkg::BIT_SERVO_ON];
					second_cond_sw <= w_data[stg_pkg::BIT_SECOND_COND];
				end
				stg_pkg::OFS_MODE: begin
					control_mode_select <= w_data[3:0];
					gain_switch_condition_select <= w_data[7:4];
				end
				stg_pkg::OFS_HOLD: third_gain_hold_time <= w_data[15:0];
				stg_pkg::OFS_SCALE: third_gain_scale <= w_data[15:0];
				stg_pkg::OFS_OFFSET: offset_torque_add <= w_data[15:0];
				stg_pkg::OFS_FWD: fwd_friction_comp <= w_data[15:0];
				stg_pkg::OFS_REV: rev_friction_comp <= w_data[15:0];
				stg_pkg::OFS_TRANS: gain_transition_time <= w_data[15:0];
				stg_pkg::OFS_GAIN1: begin
					first_position_loop_gain <= w_data[15:0];
					first_speed_prop_gain <= w_data[31:16];
				end
				stg_pkg::OFS_GAIN2: begin
					second_position_loop_gain <= w_data[15:0];
					second_speed_prop_gain <= w_data[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel: one-cycle answer after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= stg_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= stg_pkg::RESP_OKAY;
			case (s_axi_araddr)
				stg_pkg::OFS_CONTROL: s_axi_rdata <= {30'h0, second_cond_sw, servo_on};
				stg_pkg::OFS_MODE: s_axi_rdata <= {24'h0, gain_switch_condition_select,
					control_mode_select};
				stg_pkg::OFS_HOLD: s_axi_rdata <= {16'h0000, third_gain_hold_time};
				stg_pkg::OFS_SCALE: s_axi_rdata <= {16'h0000, third_gain_scale};
				stg_pkg::OFS_OFFSET: s_axi_rdata <= {16'h0000, offset_torque_add};
				stg_pkg::OFS_FWD: s_axi_rdata <= {16'h0000, fwd_friction_comp};
				stg_pkg::OFS_REV: s_axi_rdata <= {16'h0000, rev_friction_comp};
				stg_pkg::OFS_TRANS: s_axi_rdata <= {16'h0000, gain_transition_time};
				stg_pkg::OFS_GAIN1: s_axi_rdata <= {first_speed_prop_gain,
					first_position_loop_gain};
				stg_pkg::OFS_GAIN2: s_axi_rdata <= {second_speed_prop_gain,
					second_position_loop_gain};
				stg_pkg::OFS_STATUS: s_axi_rdata <= {26'h0, cmd_seen, cmd_dir, 1'b0, gain_state};
				stg_pkg::OFS_GAINOUT: s_axi_rdata <= {16'(speed_prop_gain), 16'(pos_loop_gain)};
				stg_pkg::OFS_COMP: s_axi_rdata <= {dynamic_term, offset_term};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= stg_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : stg_third_gain_friction

// File: tb/stg_assertions.sv
`timescale 1ns/1ps
module stg_checker #(
	parameter int unsigned TORQ_W = 16
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Loop outputs.
	input wire logic signed [TORQ_W-1:0] torque_out,
	input wire logic third_gain_active
);
	// Everything here lives in the single control clock domain.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Bus answers: timing, holding and back-pressure.
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped early");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped early");
	a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
		s_axi_rdata == 32'h0000_0000) else $error("refused read returned data");
	// Leaving reset the loop outputs must start clear.
	a_reset_clear: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& torque_out == '0 && !third_gain_active) else $error("outputs not clear");
	c_third: cover property ($rose(third_gain_active));
	c_werr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	c_rerr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : stg_checker

bind stg_third_gain_friction stg_checker #(.TORQ_W(TORQ_W)) u_chk (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.torque_out(torque_out), .third_gain_active(third_gain_active)
);

// File: tb/stg_host_model.sv
`timescale 1ns/1ps
module stg_host_model (
	// Clock.
	input wire logic aclk,
	// Positional command.
	output logic cmd_valid,
	output logic cmd_reverse
);
	// Quiet at time zero.
	initial begin
		cmd_valid = 1'b0;
		cmd_reverse = 1'b0;
	end
	// One pulse per command; the direction flips afterwards so a stale level is never trusted.
	task automatic send(input logic rev);
		@(posedge aclk);
		cmd_valid <= 1'b1;
		cmd_reverse <= rev;
		@(posedge aclk);
		cmd_valid <= 1'b0;
		cmd_reverse <= ~rev;
	endtask : send
endmodule : stg_host_model

// File: tb/servo_third_gain_and_friction_comp_test.sv
`timescale 1ns/1ps
module servo_third_gain_and_friction_comp_test;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, act, cmd_valid, cmd_reverse;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [1:0] bresp, rresp, rd_r;
	logic signed [15:0] torque_in, torque_out;
	logic [15:0] pg, sg;
	logic [3:0] wstrb;
	logic mid;
	int fail_count, compares, n;

	stg_host_model host (.aclk(aclk), .cmd_valid(cmd_valid), .cmd_reverse(cmd_reverse));
	stg_third_gain_friction uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_valid(cmd_valid),
		.cmd_reverse(cmd_reverse), .torque_in(torque_in), .pos_loop_gain(pg),
		.speed_prop_gain(sg), .torque_out(torque_out), .third_gain_active(act));

	// Free-running 125 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// Handshakes are judged at the rising edge itself; each valid drops right after its edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00,
		input logic [3:0] s = 4'hF);
		logic got;
		logic [1:0] r;
		got = 1'b0;
		r = 2'b11;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 40 && !got; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			got = bvalid;
			r = bresp;
		end
		bready <= 1'b0;
		chk(32'(r), 32'(e));
		if (!got) begin
			fail_count++;
			summarize();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic got;
		got = 1'b0;
		rd_d = 32'hFFFF_FFFF;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 40 && !got; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			got = rvalid;
			rd_d = rdata;
			rd_r = rresp;
		end
		rready <= 1'b0;
		if (!got) begin
			fail_count++;
			summarize();
		end
	endtask : rd

	task automatic settle();
		repeat (4) @(negedge aclk);
	endtask : settle

	// Counts cycles until the third gain flag reaches the level asked for.
	task automatic wait_act(input logic lvl);
		n = 0;
		@(negedge aclk);
		while (act !== lvl && n < 100) begin
			@(negedge aclk);
			n++;
		end
		if (n == 100) begin
			fail_count++;
			summarize();
		end
	endtask : wait_act

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		torque_in = 16'h0100;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Register defaults and refused accesses.
		rd(stg_pkg::OFS_SCALE);
		chk(rd_d, 32'h0000_0064);
		rd(stg_pkg::OFS_STATUS);
		chk(rd_d & 32'h0000_0038, 32'h0000_0000);
		rd(8'h40);
		chk({rd_d[29:0], rd_r}, 32'h0000_0002);
		wr(stg_pkg::OFS_STATUS, 32'h0000_0001, stg_pkg::RESP_SLVERR);
		wr(8'h06, 32'h0000_0001, stg_pkg::RESP_SLVERR);
		// A write with the low byte lane off is answered but leaves the register alone.
		wr(stg_pkg::OFS_SCALE, 32'h0000_1234, stg_pkg::RESP_OKAY, 4'h0);
		rd(stg_pkg::OFS_SCALE);
		chk(rd_d, 32'h0000_0064);
		$display("test registers done");
		// Friction terms per mode and direction.
		wr(stg_pkg::OFS_OFFSET, 32'h0000_0010);
		wr(stg_pkg::OFS_FWD, 32'h0000_0005);
		wr(stg_pkg::OFS_REV, 32'h0000_0007);
		wr(stg_pkg::OFS_MODE, 32'(stg_pkg::MODE_TORQUE));
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		host.send(1'b0);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_0100);
		wr(stg_pkg::OFS_MODE, 32'(stg_pkg::MODE_VELOCITY));
		host.send(1'b0);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_0110);
		// After servo-on in position mode the old terms stand until a command, new offset or not.
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0000);
		wr(stg_pkg::OFS_MODE, 32'(stg_pkg::MODE_POSITION));
		wr(stg_pkg::OFS_OFFSET, 32'h0000_0020);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_0110);
		host.send(1'b0);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_0125);
		@(posedge aclk);
		torque_in <= 16'hFF00;
		host.send(1'b1);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_FF27);
		rd(stg_pkg::OFS_STATUS);
		chk(rd_d & 32'h0000_0038, 32'h0000_0030);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0000);
		settle();
		chk({16'h0000, torque_out}, 32'h0000_FF00);
		rd(stg_pkg::OFS_STATUS);
		chk(rd_d & 32'h0000_0038, 32'h0000_0000);
		$display("test friction done");
		// Gain scheduling: second, ramp, third, first.
		wr(stg_pkg::OFS_GAIN1, 32'h00C8_0064);
		wr(stg_pkg::OFS_GAIN2, 32'h003C_0032);
		wr(stg_pkg::OFS_SCALE, 32'h0000_0096);
		wr(stg_pkg::OFS_HOLD, 32'h0000_0028);
		wr(stg_pkg::OFS_TRANS, 32'h0000_0002);
		wr(stg_pkg::OFS_MODE, 32'(stg_pkg::MODE_FULL_CLOSED));
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0003);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		wait_act(1'b1);
		// The ramp passes the halfway gain on its way from second to third.
		mid = 1'b0;
		for (n = 0; n < 50 && pg !== 16'h0096; n++) begin
			mid = mid | (pg == 16'h0064);
			@(negedge aclk);
		end
		chk(32'(mid), 32'h0000_0001);
		chk({sg, pg}, 32'h012C_0096);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0003);
		settle();
		chk({sg, pg}, 32'h003C_0032);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		wait_act(1'b1);
		wait_act(1'b0);
		chk(32'(n >= 38 && n <= 46), 32'h0000_0001);
		settle();
		chk({sg, pg}, 32'h00C8_0064);
		// Hold 0 and scale 100 make the third gain period carry the first gains.
		wr(stg_pkg::OFS_HOLD, 32'h0000_0000);
		wr(stg_pkg::OFS_SCALE, 32'h0000_0064);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0003);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		wait_act(1'b1);
		for (n = 0; n < 20 && pg !== 16'h0064; n++) @(negedge aclk);
		chk({sg, pg}, 32'h00C8_0064);
		wait_act(1'b0);
		settle();
		chk({sg, pg}, 32'h00C8_0064);
		// No third gain period outside position modes.
		wr(stg_pkg::OFS_MODE, 32'(stg_pkg::MODE_VELOCITY));
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0003);
		wr(stg_pkg::OFS_CONTROL, 32'h0000_0001);
		for (n = 0; n < 30 && act !== 1'b1; n++) @(negedge aclk);
		chk(32'(n), 32'h0000_001E);
		// Selector 7: a command alone acts as the switching condition.
		wr(stg_pkg::OFS_MODE, 32'h0000_0070);
		host.send(1'b0);
		for (n = 0; n < 20 && act !== 1'b1; n++) @(negedge aclk);
		chk(32'(act), 32'h0000_0001);
		$display("test gains done");
		summarize();
	end
endmodule : servo_third_gain_and_friction_comp_test
